// ==== logic/rx_path_pkg.sv ====
// constants, types and functional notes for the receive gain, filter and sample datapath
package rx_path_pkg;
    localparam int SAMPLE_W = 12;
    localparam int REDUCED_W = 5;
    localparam int GAIN_W = 5;
    localparam int TARGET_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int CUTOFF_LOW_NUM = 64;
    localparam int CUTOFF_HIGH_NUM = 158;
    localparam int CUTOFF_DEN_BASE = 64;
    // gain code 0 means -6 dB, steps of 2 dB
    localparam logic [4:0] GAIN_CODE_MAX_NARROW = 5'h15;
    localparam logic [4:0] GAIN_CODE_MAX_WIDE = 5'h12;
    localparam int PIN_HOLD_CYCLES = 3;
    localparam int SW_STAGE_DELAY_CYCLES = 7;
    // extra continuous-stage settling for the outside loop, in ns
    localparam int CONT_SETTLE_MIN_NS = 45;
    localparam int CONT_SETTLE_MAX_NS = 70;
    localparam int CLK_PERIOD_NS = 8;
    localparam int CONT_SETTLE_MIN_CYC = (CONT_SETTLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // high-pass coefficients in q1.17: 0.99994 and 0.98466
    localparam int COEF_FRAC = 17;
    localparam logic signed [18:0] HPF_ZERO_COEF = 19'sh1fff8;
    localparam logic signed [18:0] HPF_POLE_COEF = 19'sh1f825;
    localparam logic signed [SAMPLE_W-1:0] SAMPLE_MAX = 12'sh7ff;
    localparam logic signed [SAMPLE_W-1:0] SAMPLE_MIN = 12'sh800;
    localparam logic [2:0] CONT_STEP_RESET = 3'h0;
    localparam logic [2:0] SW_STEP_RESET = 3'h0;
    typedef enum logic [1:0] {
        PIN_IDLE = 2'b00,
        PIN_HOLD = 2'b01,
        PIN_DONE = 2'b10
    } pin_state_t;
endpackage : rx_path_pkg

// ==== logic/sample_fifo.sv ====
// synchronous valid/ready sample fifo with parameterised width and depth
`timescale 1ns/1ps
module sample_fifo
#(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
)
(
    // clocking
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    // fill side
    input wire logic i_valid,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_ready,
    // drain side
    output logic o_valid,
    output logic [WIDTH-1:0] o_data,
    input wire logic i_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    // pointer and count next state
    always_comb
    begin
        push = i_ce && i_valid && (cnt_q < (AW+1)'(DEPTH));
        pop = i_ce && i_ready && (cnt_q != '0);
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage has no reset; only written entries are ever read
    always_ff @(posedge i_clk)
    begin
        if (push)
            mem_q[wr_q] <= i_data;
    end

    assign o_ready = cnt_q < (AW+1)'(DEPTH);
    assign o_valid = cnt_q != '0;
    assign o_data = mem_q[rd_q];

    chk_fifo_no_overflow: assert property (@(posedge i_clk) disable iff (!i_resetn)
        cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : sample_fifo

// ==== logic/hp_filter.sv ====
// bypassable single-pole iir high-pass with saturation to the sample range
`timescale 1ns/1ps
module hp_filter
    import rx_path_pkg::*;
(
    // clocking
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    // control
    input wire logic i_bypass,
    // samples
    input wire logic i_valid,
    input wire logic signed [SAMPLE_W-1:0] i_sample,
    output logic o_valid,
    output logic signed [SAMPLE_W-1:0] o_sample
);
    logic signed [SAMPLE_W-1:0] x_prev_q, x_prev_d;
    logic signed [SAMPLE_W+COEF_FRAC:0] y_q, y_d;
    logic signed [SAMPLE_W-1:0] out_q, out_d;
    logic vld_q, vld_d;
    logic signed [SAMPLE_W+COEF_FRAC+20:0] acc;
    logic signed [SAMPLE_W+3:0] y_int;

    // y[n] = x[n] - a0*x[n-1] + p*y[n-1], internal state keeps fraction bits
    always_comb
    begin
        acc = ((SAMPLE_W+COEF_FRAC+21)'(i_sample) <<< COEF_FRAC)
            - (SAMPLE_W+COEF_FRAC+21)'(x_prev_q) * HPF_ZERO_COEF
            + (((SAMPLE_W+COEF_FRAC+21)'(y_q) * HPF_POLE_COEF) >>> COEF_FRAC);
        y_int = (SAMPLE_W+4)'(acc >>> COEF_FRAC);
        x_prev_d = x_prev_q;
        y_d = y_q;
        out_d = out_q;
        vld_d = 1'b0;
        if (i_valid)
        begin
            x_prev_d = i_sample;
            y_d = (SAMPLE_W+COEF_FRAC+1)'(acc);
            vld_d = 1'b1;
            if (y_int > (SAMPLE_W+4)'(SAMPLE_MAX))
                out_d = SAMPLE_MAX;
            else if (y_int < (SAMPLE_W+4)'(SAMPLE_MIN))
                out_d = SAMPLE_MIN;
            else
                out_d = SAMPLE_W'(y_int);
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            x_prev_q <= '0;
            y_q <= '0;
            out_q <= '0;
            vld_q <= 1'b0;
        end
        else if (i_ce)
        begin
            x_prev_q <= x_prev_d;
            y_q <= y_d;
            out_q <= out_d;
            vld_q <= vld_d;
        end
    end

    // bypass takes the sample straight through, saving the register stage
    assign o_valid = i_bypass ? i_valid : vld_q;
    assign o_sample = i_bypass ? i_sample : out_q;

    chk_hpf_latency_one: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_ce && i_valid && !i_bypass) |=> (vld_q || !i_ce)) else $error("filtered sample late");
endmodule : hp_filter

// ==== logic/rx_gain_filter_adc_datapath.sv ====
// receive gain decode, filter control and sample formatting datapath
`timescale 1ns/1ps
module rx_gain_filter_adc_datapath
    import rx_path_pkg::*;
(
    // clocking
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ce,
    // configuration
    input wire logic i_lpf_bypass,
    input wire logic i_wide_band,
    input wire logic [TARGET_W-1:0] i_tune_target,
    input wire logic i_hpf_bypass,
    input wire logic i_reduced_mode,
    // gain from the serial register side
    input wire logic i_reg_gain_we,
    input wire logic [GAIN_W-1:0] i_reg_gain,
    // gain from the transmit pins
    input wire logic i_gain_strobe,
    input wire logic i_nibble_phase,
    input wire logic [5:0] i_tx_pins,
    // converter samples, already signed, with over-range flags
    input wire logic i_adc_valid,
    input wire logic signed [SAMPLE_W-1:0] i_adc_sample,
    input wire logic i_adc_over_pos,
    input wire logic i_adc_over_neg,
    // analog controls
    output logic [2:0] o_cont_step,
    output logic [2:0] o_sw_step,
    output logic o_lpf_route_bypass,
    output logic o_lpf_high_band,
    output logic [8:0] o_cutoff_num,
    output logic [8:0] o_cutoff_den,
    output logic [GAIN_W-1:0] o_gain_code,
    output logic o_gain_pulse,
    output logic o_cont_changed,
    // sample stream
    output logic o_valid,
    output logic signed [SAMPLE_W-1:0] o_sample,
    input wire logic i_ready,
    output logic o_overflow
);
    logic [GAIN_W-1:0] gain_q, gain_d;
    logic [2:0] cont_q, cont_d, sw_q, sw_d;
    logic byp_q, byp_d, band_q, band_d;
    logic [8:0] num_q, num_d, den_q, den_d;
    logic pulse_q, pulse_d, cchg_q, cchg_d, ovf_q, ovf_d;
    // settle tracking of a switched-stage-only gain change; the analog delay is fixed,
    // so a plain countdown marks the first sample that carries the new gain
    logic [2:0] sw_wait_q, sw_wait_d;
    logic sw_seen_q, sw_seen_d;
    pin_state_t pin_q, pin_d;
    logic [1:0] hold_q, hold_d;
    logic [GAIN_W-1:0] pin_val_q, pin_val_d;
    logic pin_commit;
    logic [GAIN_W-1:0] new_gain, clamped;
    logic gain_load;
    logic signed [SAMPLE_W-1:0] fmt_sample;
    logic fmt_valid, hp_valid, fifo_ready, f_valid;
    logic signed [SAMPLE_W-1:0] hp_sample, f_data;
    logic valid_q, valid_d;
    logic signed [SAMPLE_W-1:0] samp_q, samp_d;

    // fixed split of a gain code into continuous and switched steps
    function automatic logic [5:0] split_gain(input logic [GAIN_W-1:0] code);
        logic [4:0] db6;
        logic [2:0] c, s;
        db6 = code;
        c = 3'h0;
        s = 3'h0;
        // total dB = 2*code - 6; take whole 6 dB blocks, at most five, into continuous stage
        if (code >= 5'h12)
            c = 3'h5;
        else if (code >= 5'h0f)
            c = 3'h4;
        else if (code >= 5'h0c)
            c = 3'h3;
        else if (code >= 5'h09)
            c = 3'h2;
        else if (code >= 5'h06)
            c = 3'h1;
        // switched index 0..6 is -6..+6 dB, remainder after the continuous part
        s = 3'(db6 - 5'(c) * 5'h3);
        if (s > 3'h6)
            s = 3'h6;
        return {c, s};
    endfunction : split_gain

    // pin capture: strobe high and phase low held for three cycles
    always_comb
    begin
        pin_d = pin_q;
        hold_d = hold_q;
        pin_val_d = i_tx_pins[5:1];
        pin_commit = 1'b0;
        unique case (pin_q)
            PIN_IDLE:
            begin
                hold_d = 2'h1;
                if (i_gain_strobe && !i_nibble_phase)
                    pin_d = PIN_HOLD;
            end
            PIN_HOLD:
            begin
                if (!i_gain_strobe || i_nibble_phase || i_tx_pins[5:1] != pin_val_q)
                    pin_d = PIN_IDLE;
                else if (hold_q == 2'(PIN_HOLD_CYCLES - 1))
                begin
                    pin_commit = 1'b1;
                    pin_d = PIN_DONE;
                end
                else
                    hold_d = hold_q + 2'h1;
            end
            PIN_DONE:
            begin
                if (!i_gain_strobe || i_nibble_phase)
                    pin_d = PIN_IDLE;
            end
            default:
                pin_d = PIN_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            pin_q <= PIN_IDLE;
            hold_q <= 2'h0;
            pin_val_q <= '0;
        end
        else if (i_ce)
        begin
            pin_q <= pin_d;
            hold_q <= hold_d;
            pin_val_q <= pin_val_d;
        end
    end

    // clamp a requested code to the top of the range allowed by the band
    function automatic logic [GAIN_W-1:0] gain_d_src(input logic [GAIN_W-1:0] g, input logic wide);
        logic [GAIN_W-1:0] top;
        top = wide ? GAIN_CODE_MAX_WIDE : GAIN_CODE_MAX_NARROW;
        return (g > top) ? top : g;
    endfunction : gain_d_src

    // gain and filter control; wide band caps the top of the range unless the filter is bypassed
    always_comb
    begin
        gain_load = i_reg_gain_we || pin_commit;
        new_gain = pin_commit ? pin_val_q : i_reg_gain;
        clamped = gain_d_src(new_gain, i_wide_band && !i_lpf_bypass);
        gain_d = gain_load ? clamped : gain_q;
        {cont_d, sw_d} = split_gain(gain_d);
        cchg_d = gain_load && (cont_d != cont_q);
        pulse_d = gain_load;
        byp_d = i_lpf_bypass;
        band_d = i_wide_band;
        num_d = i_wide_band ? 9'(CUTOFF_HIGH_NUM) : 9'(CUTOFF_LOW_NUM);
        den_d = 9'(CUTOFF_DEN_BASE) + 9'(i_tune_target);
        // switched-only change: count down until the new gain shows in the samples
        sw_wait_d = (sw_wait_q != 3'h0) ? sw_wait_q - 3'h1 : 3'h0;
        if (gain_load && (cont_d == cont_q) && (sw_d != sw_q))
            sw_wait_d = 3'(SW_STAGE_DELAY_CYCLES);
        sw_seen_d = (sw_wait_q == 3'h1);
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            gain_q <= '0;
            cont_q <= CONT_STEP_RESET;
            sw_q <= SW_STEP_RESET;
            byp_q <= 1'b0;
            band_q <= 1'b0;
            num_q <= '0;
            den_q <= '0;
            pulse_q <= 1'b0;
            cchg_q <= 1'b0;
            sw_wait_q <= 3'h0;
            sw_seen_q <= 1'b0;
        end
        else if (i_ce)
        begin
            gain_q <= gain_d;
            cont_q <= cont_d;
            sw_q <= sw_d;
            byp_q <= byp_d;
            band_q <= band_d;
            num_q <= num_d;
            den_q <= den_d;
            pulse_q <= pulse_d;
            cchg_q <= cchg_d;
            sw_wait_q <= sw_wait_d;
            sw_seen_q <= sw_seen_d;
        end
    end

    // saturate over-range codes, then narrow in reduced mode
    always_comb
    begin
        fmt_valid = i_adc_valid && i_ce;
        if (i_adc_over_pos)
            fmt_sample = SAMPLE_MAX;
        else if (i_adc_over_neg)
            fmt_sample = SAMPLE_MIN;
        else
            fmt_sample = i_adc_sample;
        if (i_reduced_mode)
            fmt_sample = {fmt_sample[SAMPLE_W-1 -: REDUCED_W], {(SAMPLE_W-REDUCED_W){1'b0}}};
    end

    hp_filter u_hpf (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_bypass(i_hpf_bypass),
        .i_valid(fmt_valid),
        .i_sample(fmt_sample),
        .o_valid(hp_valid),
        .o_sample(hp_sample)
    );

    // the fifo absorbs consumer stalls; a full fifo drops and flags the sample
    sample_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_valid(hp_valid),
        .i_data(hp_sample),
        .o_ready(fifo_ready),
        .o_valid(f_valid),
        .o_data(f_data),
        .i_ready(!valid_q || i_ready)
    );

    // output register; overflow is sticky until reset
    always_comb
    begin
        valid_d = valid_q;
        samp_d = samp_q;
        if (!valid_q || i_ready)
        begin
            valid_d = f_valid;
            samp_d = f_valid ? f_data : samp_q;
        end
        ovf_d = ovf_q || (hp_valid && !fifo_ready);
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            valid_q <= 1'b0;
            samp_q <= '0;
            ovf_q <= 1'b0;
        end
        else if (i_ce)
        begin
            valid_q <= valid_d;
            samp_q <= samp_d;
            ovf_q <= ovf_d;
        end
    end

    assign o_cont_step = cont_q;
    assign o_sw_step = sw_q;
    assign o_lpf_route_bypass = byp_q;
    assign o_lpf_high_band = band_q;
    assign o_cutoff_num = num_q;
    assign o_cutoff_den = den_q;
    assign o_gain_code = gain_q;
    assign o_gain_pulse = pulse_q;
    assign o_cont_changed = cchg_q;
    assign o_valid = valid_q;
    assign o_sample = samp_q;
    assign o_overflow = ovf_q;

    chk_gain_wide_cap: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_ce && gain_load && i_wide_band && !i_lpf_bypass) |=> gain_q <= GAIN_CODE_MAX_WIDE)
        else $error("wide band gain above cap");
    chk_gain_split_sum: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (5'(cont_q) * 5'h3 + 5'(sw_q) == gain_q) || gain_q > 5'h15) else $error("gain split mismatch");
    chk_lpf_bypass_follow: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_ce |=> o_lpf_route_bypass == $past(i_lpf_bypass)) else $error("bypass not routed");
    chk_cutoff_den_val: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_ce |=> o_cutoff_den == 9'(CUTOFF_DEN_BASE) + 9'($past(i_tune_target))) else $error("cutoff wrong");
    chk_gain_immediate: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_ce && i_reg_gain_we && !pin_commit && !(i_wide_band && !i_lpf_bypass)) |=>
        gain_q == $past(i_reg_gain) || $past(i_reg_gain) > 5'h15)
        else $error("gain not applied");
    chk_pin_three_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
        pin_commit |-> (pin_q == PIN_HOLD && hold_q == 2'h2)) else $error("pin commit early");
    chk_pin_gain_load: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (i_ce && pin_commit && !(i_wide_band && !i_lpf_bypass)) |=> gain_q == $past(pin_val_q) || $past(pin_val_q) > 5'h15)
        else $error("pin gain lost");
    chk_ovf_sticky: assert property (@(posedge i_clk) disable iff (!i_resetn)
        ovf_q |=> ovf_q) else $error("overflow flag cleared");
    cov_pin_write: cover property (@(posedge i_clk) pin_commit);
    cov_cont_change: cover property (@(posedge i_clk) o_cont_changed);
    cov_fifo_full: cover property (@(posedge i_clk) !fifo_ready);
    cov_sw_settle: cover property (@(posedge i_clk) disable iff (!i_resetn) sw_seen_q);
endmodule : rx_gain_filter_adc_datapath

// ==== sim/sample_sink.sv ====
// consumer model of the receive sample stream, prompt or stalling
`timescale 1ns/1ps
module sample_sink
    import rx_path_pkg::*;
(
    // clocking
    input wire logic i_clk,
    // stream
    input wire logic i_valid,
    input wire logic signed [SAMPLE_W-1:0] i_sample,
    output logic o_ready,
    // behaviour
    input wire logic i_stall,
    input wire logic i_slow
);
    logic signed [SAMPLE_W-1:0] got[$];
    logic [SAMPLE_W-1:0] last_ob;
    logic [7:0] lfsr_q = 8'h5a;
    initial o_ready = 1'b0;
    // ready moves only just after an edge, so each word is taken once
    always @(posedge i_clk)
    begin
        if (i_valid && o_ready)
        begin
            got.push_back(i_sample);
            last_ob <= {~i_sample[SAMPLE_W-1], i_sample[SAMPLE_W-2:0]};
        end
        lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
        o_ready <= !i_stall && (!i_slow || lfsr_q[0]);
    end
endmodule : sample_sink

// ==== sim/rx_gain_filter_adc_datapath_tb_top.sv ====
// self-checking bench of the receive gain, filter and sample datapath
`timescale 1ns/1ps
module rx_gain_filter_adc_datapath_tb_top;
    import rx_path_pkg::*;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic lpf_bypass = 1'b0, wide_band = 1'b0, hpf_bypass = 1'b1, reduced_mode = 1'b0;
    logic [7:0] tune_target = 8'h00;
    logic reg_gain_we = 1'b0, gain_strobe = 1'b0, nibble_phase = 1'b0;
    logic ce = 1'b1;
    logic [4:0] reg_gain = 5'h00;
    logic [5:0] tx_pins = 6'h00;
    logic adc_valid = 1'b0, over_pos = 1'b0, over_neg = 1'b0;
    logic signed [SAMPLE_W-1:0] adc_sample = 12'sh000;
    logic [2:0] cont_step, sw_step;
    logic route_bypass, high_band, gain_pulse, cont_changed, dut_valid, ready, overflow;
    logic [8:0] cutoff_num, cutoff_den;
    logic [4:0] gain_code;
    logic signed [SAMPLE_W-1:0] dut_sample;
    logic stall = 1'b1, slow = 1'b0;
    logic [31:0] seed = 32'hc728;
    int miscompares = 0;
    int n_checks = 0;

    // clock and reset
    initial forever #4 i_clk = ~i_clk;
    initial
    begin
        repeat (20) @(negedge i_clk);
        i_resetn = 1'b1;
    end

    rx_gain_filter_adc_datapath u_dut (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(ce),
        .i_lpf_bypass(lpf_bypass), .i_wide_band(wide_band), .i_tune_target(tune_target),
        .i_hpf_bypass(hpf_bypass), .i_reduced_mode(reduced_mode),
        .i_reg_gain_we(reg_gain_we), .i_reg_gain(reg_gain),
        .i_gain_strobe(gain_strobe), .i_nibble_phase(nibble_phase), .i_tx_pins(tx_pins),
        .i_adc_valid(adc_valid), .i_adc_sample(adc_sample),
        .i_adc_over_pos(over_pos), .i_adc_over_neg(over_neg),
        .o_cont_step(cont_step), .o_sw_step(sw_step), .o_lpf_route_bypass(route_bypass),
        .o_lpf_high_band(high_band), .o_cutoff_num(cutoff_num), .o_cutoff_den(cutoff_den),
        .o_gain_code(gain_code), .o_gain_pulse(gain_pulse), .o_cont_changed(cont_changed),
        .o_valid(dut_valid), .o_sample(dut_sample), .i_ready(ready), .o_overflow(overflow)
    );

    sample_sink u_sink (
        .i_clk(i_clk), .i_valid(dut_valid), .i_sample(dut_sample), .o_ready(ready),
        .i_stall(stall), .i_slow(slow)
    );

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // saturation first, then reduced mode keeps only the top five bits
    function automatic logic [11:0] exp_sample(logic [11:0] x, logic op, logic on, logic red);
        logic [11:0] y;
        y = op ? SAMPLE_MAX : (on ? SAMPLE_MIN : x);
        return red ? {y[11:7], 7'h00} : y;
    endfunction : exp_sample

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    // one register write; returns at the edge after the take
    task automatic reg_write(input logic [4:0] c);
        @(negedge i_clk);
        reg_gain_we = 1'b1;
        reg_gain = c;
        tune_target = 8'(rnd());
        @(negedge i_clk);
        reg_gain_we = 1'b0;
    endtask : reg_write

    task automatic pin_write(input logic [4:0] c, input int n, input logic ph);
        logic [31:0] r;
        r = rnd();
        @(negedge i_clk);
        gain_strobe = 1'b1;
        nibble_phase = ph;
        tx_pins = {c, r[0]};
        repeat (n) @(negedge i_clk);
        gain_strobe = 1'b0;
        nibble_phase = 1'b0;
        @(negedge i_clk);
    endtask : pin_write

    task automatic send(input logic [11:0] x, input logic op, input logic on);
        @(negedge i_clk);
        adc_valid = 1'b1;
        adc_sample = x;
        over_pos = op;
        over_neg = on;
        @(negedge i_clk);
        adc_valid = 1'b0;
    endtask : send

    // cycles from the take edge until the word shows, fifo empty
    task automatic latency(output int n);
        send(12'h123, 1'b0, 1'b0);
        n = 1;
        while (!dut_valid && n < 10)
        begin
            @(negedge i_clk);
            n++;
        end
        repeat (4) @(negedge i_clk);
    endtask : latency

    // watchdog sized well above the roughly 1600 cycles of the run
    initial
    begin
        #(8 * 20000);
        miscompares++;
        finish_test();
    end

    initial
    begin
        logic [4:0] cap, e;
        logic [2:0] old;
        logic [31:0] v;
        logic [11:0] exq[$];
        int n0, n1;
        wait (i_resetn);
        check(overflow, 1'b0);
        // gain codes over narrow, wide and bypassed filter settings
        for (int w = 0; w < 3; w++)
        begin
            wide_band = (w != 0);
            lpf_bypass = (w == 2);
            cap = (w == 1) ? GAIN_CODE_MAX_WIDE : GAIN_CODE_MAX_NARROW;
            for (int c = 0; c < 32; c++)
            begin
                e = (c > cap) ? cap : c;
                old = cont_step;
                reg_write(c);
                check(gain_code, e);
                check(3 * cont_step + sw_step, e);
                check(cont_step <= 5 && sw_step <= 6, 1);
                check(gain_pulse, 1'b1);
                check(cont_changed, cont_step != old);
                check(route_bypass, w == 2);
                check(cutoff_num, (w != 0) ? CUTOFF_HIGH_NUM : CUTOFF_LOW_NUM);
                check(cutoff_den, CUTOFF_DEN_BASE + tune_target);
                @(negedge i_clk);
                check(gain_pulse, 1'b0);
            end
        end
        // pin writes: short hold and wrong phase are refused
        wide_band = 1'b0;
        lpf_bypass = 1'b0;
        reg_write(5'h04);
        pin_write(5'h0b, 2, 1'b0);
        check(gain_code, 5'h04);
        pin_write(5'h0b, 3, 1'b1);
        check(gain_code, 5'h04);
        for (int i = 0; i < 4; i++)
        begin
            v = (i == 0) ? 32'h0b : rnd();
            pin_write(v[4:0], 3, 1'b0);
            e = (v[4:0] > GAIN_CODE_MAX_NARROW) ? GAIN_CODE_MAX_NARROW : v[4:0];
            check(gain_code, e);
        end
        // a write while the clock enable is low must not land
        ce = 1'b0;
        reg_write(5'h02);
        check(gain_code, e);
        ce = 1'b1;
        // latency with and without the high-pass
        stall = 1'b0;
        u_sink.got.delete();
        latency(n0);
        check(u_sink.got[0], 12'h123);
        hpf_bypass = 1'b0;
        latency(n1);
        check(n0, 2);
        check(n1, 3);
        // random stream through a slow consumer, both precisions
        hpf_bypass = 1'b1;
        slow = 1'b1;
        for (int r = 0; r < 2; r++)
        begin
            reduced_mode = r;
            u_sink.got.delete();
            exq.delete();
            for (int i = 0; i < 40; i++)
            begin
                v = rnd();
                exq.push_back(exp_sample(v[11:0], v[15:13] == 0 || i == 0, v[18:16] == 0, r));
                send(v[11:0], v[15:13] == 0 || i == 0, v[18:16] == 0);
            end
            repeat (200) @(negedge i_clk);
            check(u_sink.got.size(), 40);
            foreach (exq[i]) check($unsigned(u_sink.got[i]), exq[i]);
            check(u_sink.last_ob, exq[39] ^ 12'h800);
        end
        // fill until refused, then drain
        reduced_mode = 1'b0;
        slow = 1'b0;
        stall = 1'b1;
        u_sink.got.delete();
        for (int i = 0; i < 24; i++) send(rnd(), 1'b0, 1'b0);
        check(overflow, 1'b1);
        stall = 1'b0;
        repeat (40) @(negedge i_clk);
        check(u_sink.got.size() >= FIFO_DEPTH && u_sink.got.size() <= FIFO_DEPTH + 3, 1);
        // dc input is removed by the high-pass
        hpf_bypass = 1'b0;
        u_sink.got.delete();
        for (int i = 0; i < 300; i++) send(12'h400, 1'b0, 1'b0);
        repeat (10) @(negedge i_clk);
        n0 = u_sink.got[u_sink.got.size() - 1];
        check(n0 < 64 && n0 > -64, 1);
        finish_test();
    end
endmodule : rx_gain_filter_adc_datapath_tb_top
